// ==== common/bis_pkg.sv ====
// Shared constants and types for the branch, increment, OR and shift executer.
`default_nettype none
package bis_pkg;

    localparam int DATA_W  = 8;
    localparam int PC_W    = 15;
    localparam int IMM_W   = 11;
    localparam int FADDR_W = 7;
    localparam int UJL_W   = 7;
    localparam int BUS_AW  = 8;
    localparam int BUS_DW  = 32;

    localparam logic [BUS_AW-1:0] ADDR_ACC    = 8'h00;
    localparam logic [BUS_AW-1:0] ADDR_UJL    = 8'h04;
    localparam logic [BUS_AW-1:0] ADDR_STATUS = 8'h08;
    localparam logic [BUS_AW-1:0] ADDR_PC     = 8'h0C;

    localparam int STAT_NULL_BIT  = 0;
    localparam int STAT_SHIFT_BIT = 1;
    localparam int PC_LOW_HI      = 10;
    localparam int UJL_FIELD_HI   = 6;
    localparam int UJL_FIELD_LO   = 3;
    localparam int OPND_MSB       = 7;

    localparam logic [DATA_W-1:0] ACC_RST   = 8'h00;
    localparam logic [UJL_W-1:0]  UJL_RST   = 7'h00;
    localparam logic [PC_W-1:0]   PC_RST    = 15'h0000;
    localparam logic [PC_W-1:0]   PC_STEP   = 15'h0001;
    localparam logic [DATA_W-1:0] DATA_ONE  = 8'h01;
    localparam logic [DATA_W-1:0] DATA_ZERO = 8'h00;
    localparam logic [DATA_W-1:0] DATA_FULL = 8'hFF;

    localparam logic TGT_ACC  = 1'b0;
    localparam logic TGT_FILE = 1'b1;

    typedef enum logic [2:0] {
        OP_NOP,
        OP_FAR_JUMP,
        OP_INCR_SKIP,
        OP_INCR_FILE,
        OP_OR_LITERAL,
        OP_OR_FILE,
        OP_SHIFT_LEFT
    } bis_op_t;

    typedef struct packed {
        bis_op_t              op;
        logic                 target_pick;
        logic [FADDR_W-1:0]   reg_addr;
        logic [IMM_W-1:0]     imm;
    } bis_instr_t;

    typedef struct packed {
        logic upd_null;
        logic upd_shift;
        logic is_jump;
        logic may_skip;
        logic to_file;
        logic writes_result;
    } bis_ctrl_t;

    typedef struct packed {
        logic [DATA_W-1:0] value;
        logic              is_null;
        logic              shift_out;
    } bis_alu_t;

    typedef struct packed {
        logic               wr_en;
        logic [FADDR_W-1:0] addr;
        logic [DATA_W-1:0]  data;
    } bis_file_wr_t;

    typedef enum logic [1:0] {
        ST_RUN,
        ST_JUMP_FLUSH,
        ST_SKIP
    } bis_state_t;

endpackage
`default_nettype wire

// ==== rtl/bis_decode.sv ====
// Instruction decoder that turns an instruction word into control flags.
`timescale 1ns/1ps
`default_nettype none
module bis_decode (
    input  wire bis_pkg::bis_instr_t instr,
    output bis_pkg::bis_ctrl_t       ctrl
);
    import bis_pkg::*;

    always_comb begin
        ctrl = '0;
        unique case (instr.op)
            OP_FAR_JUMP: begin
                ctrl.is_jump = 1'b1;
            end
            OP_INCR_SKIP: begin
                ctrl.may_skip      = 1'b1;
                ctrl.writes_result = 1'b1;
                ctrl.to_file       = instr.target_pick;
            end
            OP_INCR_FILE, OP_OR_FILE: begin
                ctrl.upd_null      = 1'b1;
                ctrl.writes_result = 1'b1;
                ctrl.to_file       = instr.target_pick;
            end
            OP_OR_LITERAL: begin
                ctrl.upd_null      = 1'b1;
                ctrl.writes_result = 1'b1;
                ctrl.to_file       = TGT_ACC;
            end
            OP_SHIFT_LEFT: begin
                ctrl.upd_null      = 1'b1;
                ctrl.upd_shift     = 1'b1;
                ctrl.writes_result = 1'b1;
                ctrl.to_file       = instr.target_pick;
            end
            OP_NOP: begin
                ctrl = '0;
            end
            default: begin
                ctrl = '0;
            end
        endcase
    end

endmodule
`default_nettype wire

// ==== rtl/bis_alu.sv ====
// Result datapath for increment, OR and left shift.
`timescale 1ns/1ps
`default_nettype none
module bis_alu (
    input  wire bis_pkg::bis_op_t      op,
    input  wire logic [7:0]            acc,
    input  wire logic [7:0]            operand,
    input  wire logic [7:0]            literal,
    output bis_pkg::bis_alu_t          res
);
    import bis_pkg::*;

    always_comb begin
        res = '0;
        unique case (op)
            OP_INCR_SKIP, OP_INCR_FILE: begin
                res.value = DATA_W'(operand + DATA_ONE);
            end
            OP_OR_LITERAL: begin
                res.value = acc | literal;
            end
            OP_OR_FILE: begin
                res.value = acc | operand;
            end
            OP_SHIFT_LEFT: begin
                res.value     = {operand[OPND_MSB-1:0], 1'b0};
                res.shift_out = operand[OPND_MSB];
            end
            default: begin
                res.value = DATA_ZERO;
            end
        endcase
        res.is_null = (res.value == DATA_ZERO);
    end

endmodule
`default_nettype wire

// ==== rtl/bis_exec.sv ====
// Executer for the far jump, increments, OR operations and left shift.
//
// Chosen here: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module bis_exec (
    input  wire logic                         sys_clk,
    input  wire logic                         rst_n,
    input  wire logic                         instr_valid,
    input  wire bis_pkg::bis_instr_t          instr,
    input  wire logic [bis_pkg::DATA_W-1:0]   file_operand,
    output logic                              instr_ready,
    output bis_pkg::bis_file_wr_t             file_wr,
    output logic [bis_pkg::PC_W-1:0]          pc_value,
    output logic [bis_pkg::DATA_W-1:0]        acc_value,
    output logic                              result_null_flag,
    output logic                              shift_out_bit,
    input  wire logic [bis_pkg::BUS_AW-1:0]   bus_addr,
    input  wire logic [bis_pkg::BUS_DW-1:0]   bus_wdata,
    input  wire logic                         bus_wr,
    input  wire logic                         bus_rd,
    output logic [bis_pkg::BUS_DW-1:0]        bus_rdata
);
    import bis_pkg::*;

    typedef struct packed {
        bis_state_t          state;
        logic [PC_W-1:0]     pc;
        logic [DATA_W-1:0]   acc;
        logic [UJL_W-1:0]    upper_jump_latch;
        logic                null_flag;
        logic                shift_flag;
        logic                ready;
        bis_file_wr_t        file_wr;
        logic [BUS_DW-1:0]   rdata;
    } bis_exec_state_t;

    localparam bis_exec_state_t ST_RESET = '{
        state:            ST_RUN,
        pc:               PC_RST,
        acc:              ACC_RST,
        upper_jump_latch: UJL_RST,
        null_flag:        1'b0,
        shift_flag:       1'b0,
        ready:            1'b1,
        file_wr:          '0,
        rdata:            '0
    };

    bis_exec_state_t st_r;
    bis_exec_state_t st_nxt;
    bis_ctrl_t       ctrl;
    bis_alu_t        alu;
    logic            take;

    bis_decode u_decode (
        .instr (instr),
        .ctrl  (ctrl)
    );

    bis_alu u_alu (
        .op      (instr.op),
        .acc     (st_r.acc),
        .operand (file_operand),
        .literal (instr.imm[DATA_W-1:0]),
        .res     (alu)
    );

    assign take = instr_valid && st_r.ready;

    always_comb begin
        st_nxt               = st_r;
        st_nxt.file_wr.wr_en = 1'b0;
        st_nxt.rdata         = '0;

        // Software access; execution below takes precedence on the accumulator.
        if (bus_wr) begin
            if (bus_addr == ADDR_ACC) begin
                st_nxt.acc = bus_wdata[DATA_W-1:0];
            end else if (bus_addr == ADDR_UJL) begin
                st_nxt.upper_jump_latch = bus_wdata[UJL_W-1:0];
            end
        end
        if (bus_rd) begin
            unique case (bus_addr)
                ADDR_ACC:    st_nxt.rdata[DATA_W-1:0] = st_r.acc;
                ADDR_UJL:    st_nxt.rdata[UJL_W-1:0]  = st_r.upper_jump_latch;
                ADDR_STATUS: begin
                    st_nxt.rdata[STAT_NULL_BIT]  = st_r.null_flag;
                    st_nxt.rdata[STAT_SHIFT_BIT] = st_r.shift_flag;
                end
                ADDR_PC:     st_nxt.rdata[PC_W-1:0]   = st_r.pc;
                default:     st_nxt.rdata             = '0;
            endcase
        end

        unique case (st_r.state)
            ST_JUMP_FLUSH: begin
                // Second cycle of the far jump: ready is held low, so no word is taken and the waiting word stays with the memory.
                st_nxt.state = ST_RUN;
                st_nxt.ready = 1'b1;
            end
            ST_SKIP: begin
                // The instruction after a zero increment-skip result runs as a NOP.
                if (take) begin
                    st_nxt.state = ST_RUN;
                    st_nxt.pc    = PC_W'(st_r.pc + PC_STEP);
                end
            end
            ST_RUN: begin
                if (take) begin
                    st_nxt.pc = PC_W'(st_r.pc + PC_STEP);
                    if (ctrl.is_jump) begin
                        st_nxt.pc[PC_LOW_HI:0] = instr.imm;
                        st_nxt.pc[PC_W-1:PC_LOW_HI+1] =
                            st_r.upper_jump_latch[UJL_FIELD_HI:UJL_FIELD_LO];
                        st_nxt.state = ST_JUMP_FLUSH;
                        st_nxt.ready = 1'b0;
                    end else if (ctrl.writes_result) begin
                        if (ctrl.to_file == TGT_FILE) begin
                            st_nxt.file_wr.wr_en = 1'b1;
                            st_nxt.file_wr.addr  = instr.reg_addr;
                            st_nxt.file_wr.data  = alu.value;
                        end else begin
                            st_nxt.acc = alu.value;
                        end
                        if (ctrl.upd_null) begin
                            st_nxt.null_flag = alu.is_null;
                        end
                        if (ctrl.upd_shift) begin
                            st_nxt.shift_flag = alu.shift_out;
                        end
                        if (ctrl.may_skip && alu.is_null) begin
                            st_nxt.state = ST_SKIP;
                        end
                    end
                end
            end
            default: begin
                st_nxt.state = ST_RUN;
                st_nxt.ready = 1'b1;
            end
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            st_r <= ST_RESET;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign instr_ready      = st_r.ready;
    assign file_wr          = st_r.file_wr;
    assign pc_value         = st_r.pc;
    assign acc_value        = st_r.acc;
    assign result_null_flag = st_r.null_flag;
    assign shift_out_bit    = st_r.shift_flag;
    assign bus_rdata        = st_r.rdata;

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_n);

    logic take_jump;
    logic take_exec;
    assign take_jump = take && st_r.state == ST_RUN && instr.op == OP_FAR_JUMP;
    assign take_exec = take && st_r.state == ST_RUN && ctrl.writes_result;

    sequence s_flush_then_ready;
        !instr_ready ##1 instr_ready;
    endsequence

    sequence s_skip_slot;
        (st_r.state == ST_SKIP) && instr_valid && instr_ready;
    endsequence

    a_jump_pc_low: assert property (
        take_jump |=> pc_value[PC_LOW_HI:0] == $past(instr.imm))
        else $error("Far jump did not load the low counter bits.");

    a_jump_pc_high: assert property (
        take_jump |=> pc_value[PC_W-1:PC_LOW_HI+1] ==
            $past(st_r.upper_jump_latch[UJL_FIELD_HI:UJL_FIELD_LO]))
        else $error("Far jump did not load the upper counter bits.");

    a_jump_two_cycles: assert property (
        take_jump |=> s_flush_then_ready)
        else $error("Far jump did not take exactly two cycles.");

    a_jump_flags_kept: assert property (
        take_jump |=> ($stable(result_null_flag) && $stable(shift_out_bit)) [*2])
        else $error("Far jump changed a flag.");

    a_dest_file: assert property (
        take_exec && ctrl.to_file |=> file_wr.wr_en &&
            file_wr.addr == $past(instr.reg_addr) && file_wr.data == $past(alu.value))
        else $error("File destination not written.");

    a_dest_acc: assert property (
        take_exec && !ctrl.to_file |=> !file_wr.wr_en && acc_value == $past(alu.value))
        else $error("Accumulator destination not written.");

    a_skip_enter: assert property (
        take_exec && instr.op == OP_INCR_SKIP |=>
            (st_r.state == ST_SKIP) == ($past(file_operand) == DATA_FULL) &&
            $stable(result_null_flag) && $stable(shift_out_bit))
        else $error("Increment-skip mishandled the skip or a flag.");

    a_skip_is_nop: assert property (
        s_skip_slot |=> !file_wr.wr_en && st_r.state == ST_RUN &&
            pc_value == PC_W'($past(pc_value) + PC_STEP) && $stable(acc_value))
        else $error("Skipped instruction was not a NOP.");

    a_incr_null: assert property (
        take_exec && instr.op == OP_INCR_FILE |=>
            result_null_flag == ($past(file_operand) == DATA_FULL))
        else $error("Increment set the null flag wrongly.");

    a_or_literal: assert property (
        take_exec && instr.op == OP_OR_LITERAL |=>
            acc_value == ($past(st_r.acc) | $past(instr.imm[DATA_W-1:0])))
        else $error("OR literal result wrong.");

    a_or_file: assert property (
        take_exec && instr.op == OP_OR_FILE |=>
            result_null_flag == (($past(st_r.acc) | $past(file_operand)) == DATA_ZERO))
        else $error("OR file null flag wrong.");

    a_shift_carry: assert property (
        take_exec && instr.op == OP_SHIFT_LEFT && ctrl.to_file |=>
            shift_out_bit == $past(file_operand[OPND_MSB]) &&
            file_wr.data == {$past(file_operand[OPND_MSB-1:0]), 1'b0})
        else $error("Left shift result or carry wrong.");

    a_single_cycle: assert property (
        take_exec && !ctrl.may_skip |=> instr_ready && st_r.state == ST_RUN)
        else $error("Single-cycle instruction stalled.");

    a_null_flag: assert property (
        take_exec && ctrl.upd_null |=> result_null_flag == ($past(alu.value) == DATA_ZERO))
        else $error("Null flag does not follow the result.");

    sequence s_zero_incr_skip;
        take_exec && instr.op == OP_INCR_SKIP && file_operand == DATA_FULL;
    endsequence

    a_jump_no_write: assert property (
        take_jump && !bus_wr |=> !file_wr.wr_en && $stable(acc_value))
        else $error("Far jump wrote a destination.");

    a_flush_refuses: assert property (
        st_r.state == ST_JUMP_FLUSH |-> !instr_ready)
        else $error("Word accepted in the second cycle of a far jump.");

    a_skip_arms_nop: assert property (
        s_zero_incr_skip |=> st_r.state == ST_SKIP && instr_ready &&
            pc_value == PC_W'($past(pc_value) + PC_STEP))
        else $error("Zero increment-skip did not arm the NOP slot.");

    a_skip_flags_kept: assert property (
        s_skip_slot |=> $stable(result_null_flag) && $stable(shift_out_bit))
        else $error("Skipped instruction changed a flag.");

    a_skip_value: assert property (
        take_exec && instr.op == OP_INCR_SKIP && ctrl.to_file |=>
            file_wr.data == DATA_W'($past(file_operand) + DATA_ONE))
        else $error("Increment-skip stored a wrong sum.");

    a_incr_value: assert property (
        take_exec && instr.op == OP_INCR_FILE && !ctrl.to_file |=>
            acc_value == DATA_W'($past(file_operand) + DATA_ONE))
        else $error("Increment stored a wrong sum.");

    a_or_literal_null: assert property (
        take_exec && instr.op == OP_OR_LITERAL |=> !file_wr.wr_en &&
            result_null_flag ==
            (($past(st_r.acc) | $past(instr.imm[DATA_W-1:0])) == DATA_ZERO))
        else $error("OR literal wrote a register or set the null flag wrongly.");

    a_or_file_value: assert property (
        take_exec && instr.op == OP_OR_FILE |=>
            (file_wr.wr_en ? file_wr.data : acc_value) ==
            ($past(st_r.acc) | $past(file_operand)))
        else $error("OR file result wrong.");

    a_shift_to_acc: assert property (
        take_exec && instr.op == OP_SHIFT_LEFT && !ctrl.to_file |=>
            shift_out_bit == $past(file_operand[OPND_MSB]) &&
            acc_value == {$past(file_operand[OPND_MSB-1:0]), 1'b0})
        else $error("Left shift into the accumulator wrong.");

    a_one_step_pc: assert property (
        take_exec |=> pc_value == PC_W'($past(pc_value) + PC_STEP))
        else $error("Single-cycle instruction did not advance the counter by one.");

    a_shift_null: assert property (
        take_exec && instr.op == OP_SHIFT_LEFT |=>
            result_null_flag == ($past(file_operand[OPND_MSB-1:0]) == 7'h00))
        else $error("Left shift set the null flag wrongly.");

endmodule
`default_nettype wire

// ==== testbench/bis_prog_mem.sv ====
// Program memory model that presents queued instruction words to the executer.
`timescale 1ns/1ps
`default_nettype none
module bis_prog_mem (
    input  wire logic                   sys_clk,
    input  wire logic                   rst_n,
    input  wire logic                   instr_ready,
    output logic                        instr_valid,
    output bis_pkg::bis_instr_t         instr,
    output logic [bis_pkg::DATA_W-1:0]  file_operand
);
    import bis_pkg::*;

    bis_instr_t        word_q[$];
    logic [DATA_W-1:0] opnd_q[$];

    function automatic void push(input bis_instr_t w, input logic [DATA_W-1:0] v);
        word_q.push_back(w);
        opnd_q.push_back(v);
    endfunction

    initial begin
        instr_valid = 1'b0;
        instr = '0;
        file_operand = 8'h00;
    end

    // A word leaves only once taken; idle lines show a pattern that changes every cycle.
    always @(posedge sys_clk) begin
        if (!rst_n) begin
            instr_valid <= 1'b0;
        end else begin
            if (instr_valid && instr_ready && word_q.size() > 0) begin
                word_q.delete(0);
                opnd_q.delete(0);
            end
            if (word_q.size() > 0) begin
                instr_valid <= 1'b1;
                instr <= word_q[0];
                file_operand <= opnd_q[0];
            end else begin
                instr_valid <= 1'b0;
                instr <= bis_instr_t'(~instr);
                file_operand <= ~file_operand;
            end
        end
    end
endmodule
`default_nettype wire

// ==== testbench/tb_branch_incr_or_shift_exec.sv ====
// Self-checking testbench for the branch, increment, OR and shift executer.
`timescale 1ns/1ps
`default_nettype none
module tb_branch_incr_or_shift_exec;
    import bis_pkg::*;

    logic                sys_clk;
    logic                rst_n;
    logic                instr_valid;
    bis_instr_t          instr;
    logic [DATA_W-1:0]   file_operand;
    logic                instr_ready;
    bis_file_wr_t        file_wr;
    logic [PC_W-1:0]     pc_value;
    logic [DATA_W-1:0]   acc_value;
    logic                result_null_flag;
    logic                shift_out_bit;
    logic [BUS_AW-1:0]   bus_addr;
    logic [BUS_DW-1:0]   bus_wdata;
    logic                bus_wr;
    logic                bus_rd;
    logic [BUS_DW-1:0]   bus_rdata;
    logic [PC_W-1:0]     pc_exp;
    int                  num_errors;
    int                  checked;

    bis_exec bis_exec_inst (
        .sys_clk(sys_clk), .rst_n(rst_n), .instr_valid(instr_valid), .instr(instr),
        .file_operand(file_operand), .instr_ready(instr_ready), .file_wr(file_wr),
        .pc_value(pc_value), .acc_value(acc_value), .result_null_flag(result_null_flag),
        .shift_out_bit(shift_out_bit), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
        .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata)
    );

    bis_prog_mem bis_prog_mem_inst (
        .sys_clk(sys_clk), .rst_n(rst_n), .instr_ready(instr_ready),
        .instr_valid(instr_valid), .instr(instr), .file_operand(file_operand)
    );

    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end

    task automatic report_and_stop();
        if (num_errors == 0 && checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic bus_write(input logic [BUS_AW-1:0] a, input logic [BUS_DW-1:0] d);
        @(posedge sys_clk);
        bus_wr <= 1'b1;
        bus_addr <= a;
        bus_wdata <= d;
        @(posedge sys_clk);
        bus_wr <= 1'b0;
        #1;
    endtask

    task automatic bus_read_check(input logic [BUS_AW-1:0] a, input logic [BUS_DW-1:0] e);
        @(posedge sys_clk);
        bus_rd <= 1'b1;
        bus_addr <= a;
        @(posedge sys_clk);
        bus_rd <= 1'b0;
        #1;
        check(bus_rdata, e);
    endtask

    task automatic issue(input bis_op_t op, input logic tgt, input logic [IMM_W-1:0] imm,
                         input logic [DATA_W-1:0] opnd);
        bis_instr_t w;
        w.op = op;
        w.target_pick = tgt;
        w.reg_addr = 7'h3C;
        w.imm = imm;
        bis_prog_mem_inst.push(w, opnd);
    endtask

    task automatic drain();
        int n;
        for (n = 0; n < 20; n++) begin
            @(posedge sys_clk);
            #1;
            if (bis_prog_mem_inst.word_q.size() == 0 && instr_valid === 1'b0) begin
                return;
            end
        end
        num_errors++;
        report_and_stop();
    endtask

    task automatic step(input bis_op_t op, input logic tgt, input logic [IMM_W-1:0] imm,
                        input logic [7:0] opnd, input logic [7:0] acc_e, input logic wr_e,
                        input logic [7:0] data_e, input logic null_e, input logic shift_e);
        issue(op, tgt, imm, opnd);
        drain();
        pc_exp = pc_exp + PC_STEP;
        check(acc_value, acc_e);
        check(file_wr.wr_en, wr_e);
        if (wr_e) begin
            check({file_wr.addr, file_wr.data}, {7'h3C, data_e});
        end
        check({shift_out_bit, result_null_flag}, {shift_e, null_e});
        check(pc_value, pc_exp);
    endtask

    task automatic t_reset();
        check({pc_value, acc_value, shift_out_bit, result_null_flag}, 32'h0);
        bus_read_check(ADDR_ACC, 32'h0);
        bus_read_check(ADDR_UJL, 32'h0);
        bus_read_check(ADDR_PC, 32'h0);
        bus_write(ADDR_STATUS, 32'h3);
        bus_read_check(ADDR_STATUS, 32'h0);
        bus_read_check(8'h10, 32'h0);
        pc_exp = PC_RST;
    endtask

    task automatic t_jump();
        step(OP_SHIFT_LEFT, 1'b0, 11'h000, 8'h80, 8'h00, 1'b0, 8'h00, 1'b1, 1'b1);
        bus_write(ADDR_UJL, 32'h5A);
        bus_read_check(ADDR_UJL, 32'h5A);
        issue(OP_FAR_JUMP, 1'b0, 11'h7FF, 8'h00);
        drain();
        check(pc_value, 15'h5FFF);
        check({instr_ready, shift_out_bit, result_null_flag}, 3'b011);
        @(posedge sys_clk);
        #1;
        check(instr_ready, 1'b1);
        pc_exp = 15'h5FFF;
        bus_read_check(ADDR_PC, 32'h5FFF);
        @(posedge sys_clk);
        #1;
        check(bus_rdata, 32'h0);
        bus_read_check(ADDR_STATUS, 32'h3);
    endtask

    task automatic t_shift_incr();
        step(OP_SHIFT_LEFT, 1'b1, 11'h000, 8'h81, 8'h00, 1'b1, 8'h02, 1'b0, 1'b1);
        step(OP_SHIFT_LEFT, 1'b0, 11'h000, 8'h40, 8'h80, 1'b0, 8'h00, 1'b0, 1'b0);
        step(OP_INCR_FILE, 1'b0, 11'h000, 8'h11, 8'h12, 1'b0, 8'h00, 1'b0, 1'b0);
        step(OP_INCR_FILE, 1'b1, 11'h000, 8'hFF, 8'h12, 1'b1, 8'h00, 1'b1, 1'b0);
    endtask

    task automatic t_or();
        step(OP_OR_LITERAL, 1'b1, 11'h000, 8'h5A, 8'h12, 1'b0, 8'h00, 1'b0, 1'b0);
        bus_write(ADDR_ACC, 32'h0);
        step(OP_OR_LITERAL, 1'b0, 11'h700, 8'h00, 8'h00, 1'b0, 8'h00, 1'b1, 1'b0);
        issue(OP_OR_LITERAL, 1'b0, 11'h001, 8'h00);
        issue(OP_OR_LITERAL, 1'b0, 11'h080, 8'h00);
        drain();
        pc_exp = pc_exp + 15'h0002;
        check({pc_value, acc_value}, {pc_exp, 8'h81});
        step(OP_OR_FILE, 1'b1, 11'h000, 8'h50, 8'h81, 1'b1, 8'hD1, 1'b0, 1'b0);
        step(OP_OR_FILE, 1'b0, 11'h000, 8'h24, 8'hA5, 1'b0, 8'h00, 1'b0, 1'b0);
    endtask

    task automatic t_skip();
        step(OP_INCR_FILE, 1'b1, 11'h000, 8'hFF, 8'hA5, 1'b1, 8'h00, 1'b1, 1'b0);
        step(OP_INCR_SKIP, 1'b1, 11'h000, 8'h22, 8'hA5, 1'b1, 8'h23, 1'b1, 1'b0);
        step(OP_INCR_FILE, 1'b0, 11'h000, 8'h00, 8'h01, 1'b0, 8'h00, 1'b0, 1'b0);
        step(OP_INCR_SKIP, 1'b0, 11'h000, 8'hFF, 8'h00, 1'b0, 8'h00, 1'b0, 1'b0);
        step(OP_INCR_FILE, 1'b1, 11'h000, 8'h07, 8'h00, 1'b0, 8'h00, 1'b0, 1'b0);
        step(OP_INCR_FILE, 1'b1, 11'h000, 8'h07, 8'h00, 1'b1, 8'h08, 1'b0, 1'b0);
        step(OP_NOP, 1'b1, 11'h000, 8'h55, 8'h00, 1'b0, 8'h00, 1'b0, 1'b0);
    endtask

    initial begin
        num_errors = 0;
        checked = 0;
        pc_exp = PC_RST;
        rst_n = 1'b0;
        bus_addr = 8'h00;
        bus_wdata = 32'h0;
        bus_wr = 1'b0;
        bus_rd = 1'b0;
        repeat (4) @(posedge sys_clk);
        rst_n <= 1'b1;
        @(posedge sys_clk);
        #1;
        t_reset();
        t_jump();
        t_shift_incr();
        t_or();
        t_skip();
        report_and_stop();
    end
endmodule
`default_nettype wire
